// >>> inc/uart_cfg_pkg.sv
package uart_cfg_pkg;
  // Register addresses on the parallel bus
  localparam logic [2:0] ADDR_HOLD_DLL   = 3'h0;
  localparam logic [2:0] ADDR_DLM_FEATURE_CONTROL   = 3'h1;
  localparam logic [2:0] ADDR_ISR_DLD    = 3'h2;
  localparam logic [2:0] ADDR_LCR        = 3'h3;
  localparam logic [2:0] ADDR_LSR        = 3'h5;
  localparam logic [2:0] ADDR_SCRATCH    = 3'h7;
  localparam logic [7:0] LCR_ENH_ACCESS  = 8'hbf;

  // Field positions
  localparam int LCR_DLAB        = 7;
  localparam int EFR_ENH_EN      = 4;
  localparam int EFR_AUTO_RTS    = 6;
  localparam int ENHANCED_MODE_SELECT_CNT_LO     = 0;
  localparam int ENHANCED_MODE_SELECT_CNT_HI     = 1;
  localparam int ENHANCED_MODE_SELECT_SEND_IMM   = 2;
  localparam int ENHANCED_MODE_SELECT_RTS_INV    = 3;
  localparam int ENHANCED_MODE_SELECT_HYST_LO    = 4;
  localparam int ENHANCED_MODE_SELECT_LSR_IMM    = 6;
  localparam int ENHANCED_MODE_SELECT_CLR_MODE   = 7;
  localparam int FEATURE_CONTROL_HYST_LO    = 0;
  localparam int FEATURE_CONTROL_IR_INV     = 2;
  localparam int FEATURE_CONTROL_AUTO_DIR   = 3;
  localparam int FEATURE_CONTROL_TABLE_LO   = 4;
  localparam int FEATURE_CONTROL_SWAP       = 6;
  localparam int FEATURE_CONTROL_TRG_SEL    = 7;
  localparam int DLD_FRAC_LO     = 0;
  localparam int DLD_SAMPLE_LO   = 4;
  localparam int DLD_SEL_LO      = 6;

  // Reset values and other constants
  localparam logic [7:0] SCRATCH_RESET = 8'hff;
  localparam logic [7:0] DLL_RESET     = 8'h01;
  localparam logic [7:0] DLM_RESET     = 8'h00;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [7:0] ISR_NONE      = 8'h01;
  localparam logic [7:0] ISR_FLOW      = 8'h10;
  localparam logic [7:0] FIFO_DEPTH    = 8'h40;

  // Divisor write steering codes
  localparam logic [1:0] SEL_SHARED = 2'h0;
  localparam logic [1:0] SEL_TX     = 2'h1;
  localparam logic [1:0] SEL_RX     = 2'h3;

  // Hysteresis in characters, index {ext[1:0], feature_control[1:0]}
  localparam logic [7:0] HYST_TABLE [16] = '{
    8'h00, 8'h04, 8'h06, 8'h08,
    8'h08, 8'h10, 8'h18, 8'h20,
    8'h28, 8'h2c, 8'h30, 8'h34,
    8'h0c, 8'h14, 8'h1c, 8'h24};
endpackage

// >>> rtl/uart_enh_cfg.sv
`timescale 1ns/1ns
module uart_enh_cfg #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  // Host register bus
  input  wire logic             CS_N,
  input  wire logic             IOR_N,
  input  wire logic             IOW_N,
  input  wire logic [2:0]       ADDR,
  input  wire logic [7:0]       D_IN,
  output logic      [7:0]       D_OUT,
  output logic                  D_OE,
  // Datapath status
  input  wire logic [CNT_W-1:0] RX_COUNT,
  input  wire logic [CNT_W-1:0] TX_COUNT,
  input  wire logic [7:0]       RX_TRIG_LEVEL,
  input  wire logic             FIFO_EN,
  input  wire logic             TX_BYTE_SENT,
  input  wire logic             THR_EMPTY,
  input  wire logic             TSR_EMPTY,
  input  wire logic             BIT_TICK,
  input  wire logic             ERR_AT_RHR,
  input  wire logic             ERR_INTO_FIFO,
  input  wire logic             XOFF_RCVD,
  input  wire logic             XON_RCVD,
  input  wire logic             SPECIAL_RCVD,
  input  wire logic             CHAR_RCVD,
  input  wire logic             GP_RTS_N,
  // Configuration and events to the datapath
  output logic      [19:0]      TX_DIVISOR,
  output logic      [19:0]      RX_DIVISOR,
  output logic      [1:0]       TX_SAMPLE_SEL,
  output logic      [1:0]       RX_SAMPLE_SEL,
  output logic                  SEND_IMMEDIATE,
  output logic                  IR_RX_INVERT,
  output logic      [1:0]       TRIG_TABLE,
  output logic      [7:0]       RX_USER_TRIG,
  output logic      [7:0]       TX_USER_TRIG,
  output logic      [7:0]       RTS_HYST,
  output logic                  RTS_N,
  output logic                  TX_INT,
  output logic                  LSR_ERR_INT,
  output logic                  XOFF_INT,
  output logic                  XON_INT,
  output logic                  SPECIAL_INT
);

  typedef struct packed {
    logic       iow_q;
    logic       ior_q;
    logic [7:0] line_control;
    logic [7:0] enhanced_feature;
    logic [7:0] scratchpad;
    logic [7:0] enhanced_mode_select;
    logic [7:0] feature_control;
    logic [1:0] dld_sel;
    logic [7:0] tx_dll;
    logic [7:0] tx_dlm;
    logic [5:0] tx_dld;
    logic [7:0] rx_dll;
    logic [7:0] rx_dlm;
    logic [5:0] rx_dld;
    logic [7:0] rx_trig;
    logic [7:0] tx_trig;
    logic       alt_tx;
    logic       xoff_f;
    logic       xon_f;
    logic       spec_f;
    logic       err_seen;
    logic       dir_tx;
    logic       dir_wait;
    logic       flow_n;
    logic       rts_n;
    logic       tx_int;
    logic       lsr_int;
    logic       imm_out;
    logic [7:0] hyst_out;
    logic [7:0] dout;
    logic       doe;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic [7:0] sat_count(input logic [CNT_W-1:0] c);
    logic [7:0] w;
    w = 8'(c);
    sat_count = (w > uart_cfg_pkg::FIFO_DEPTH) ? uart_cfg_pkg::FIFO_DEPTH : w;
  endfunction

  logic       cs;
  logic       wr;
  logic       rd;
  logic       bf;
  logic       dlab;
  logic       swap;
  logic [7:0] level;
  logic [7:0] hyst;
  logic [8:0] upper;
  logic [8:0] lower;
  logic [7:0] rxc;
  logic [1:0] sel;
  logic       auto_dir;

  always_comb begin
    next_cur = cur;
    cs       = ~CS_N;
    wr       = cs & ~IOW_N & cur.iow_q;
    rd       = cs & ~IOR_N & cur.ior_q;
    bf       = (cur.line_control == uart_cfg_pkg::LCR_ENH_ACCESS);
    dlab     = cur.line_control[uart_cfg_pkg::LCR_DLAB] & ~bf;
    swap     = cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_SWAP];
    auto_dir = cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_AUTO_DIR];
    rxc      = sat_count(RX_COUNT);
    sel      = D_IN[uart_cfg_pkg::DLD_SEL_LO +: 2];
    next_cur.iow_q = IOW_N;
    next_cur.ior_q = IOR_N;

    // Level count view for the selected direction
    if (cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_TRG_SEL]) begin
      level = sat_count(TX_COUNT);
    end else begin
      level = rxc;
    end

    // Event flags: a new event in the clearing cycle still sets the flag
    if (rd && !bf && !dlab && ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
      next_cur.xoff_f = 1'b0;
      next_cur.spec_f = 1'b0;
      next_cur.xon_f  = 1'b0;
    end
    if (!cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_CLR_MODE]) begin
      if (XON_RCVD) begin
        next_cur.xoff_f = 1'b0;
      end
      if (CHAR_RCVD) begin
        next_cur.spec_f = 1'b0;
      end
    end
    if (XOFF_RCVD) begin
      next_cur.xoff_f = 1'b1;
    end
    if (XON_RCVD) begin
      next_cur.xon_f = 1'b1;
    end
    if (SPECIAL_RCVD) begin
      next_cur.spec_f = 1'b1;
    end

    // Immediate error indication is held until the line status is read
    if (rd && ADDR == uart_cfg_pkg::ADDR_LSR) begin
      next_cur.err_seen = 1'b0;
    end
    if (ERR_INTO_FIFO) begin
      next_cur.err_seen = 1'b1;
    end

    // Send-immediate clears after its byte; a new write in that cycle wins
    if (TX_BYTE_SENT) begin
      next_cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_SEND_IMM] = 1'b0;
    end

    // Register writes
    if (wr) begin
      if (ADDR == uart_cfg_pkg::ADDR_LCR) begin
        next_cur.line_control = D_IN;
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_HOLD_DLL) begin
        if (cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_TRG_SEL]) begin
          next_cur.tx_trig = D_IN;
        end else begin
          next_cur.rx_trig = D_IN;
        end
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_DLM_FEATURE_CONTROL) begin
        next_cur.feature_control = D_IN;
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
        next_cur.enhanced_feature = D_IN;
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_HOLD_DLL) begin
        if (cur.dld_sel == uart_cfg_pkg::SEL_SHARED || cur.dld_sel == uart_cfg_pkg::SEL_TX) begin
          next_cur.tx_dll = D_IN;
        end
        if (cur.dld_sel == uart_cfg_pkg::SEL_SHARED || cur.dld_sel == uart_cfg_pkg::SEL_RX) begin
          next_cur.rx_dll = D_IN;
        end
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_DLM_FEATURE_CONTROL) begin
        if (cur.dld_sel == uart_cfg_pkg::SEL_SHARED || cur.dld_sel == uart_cfg_pkg::SEL_TX) begin
          next_cur.tx_dlm = D_IN;
        end
        if (cur.dld_sel == uart_cfg_pkg::SEL_SHARED || cur.dld_sel == uart_cfg_pkg::SEL_RX) begin
          next_cur.rx_dlm = D_IN;
        end
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
        // Writes are dropped while enhanced functions are locked
        if (cur.enhanced_feature[uart_cfg_pkg::EFR_ENH_EN]) begin
          next_cur.dld_sel = sel;
          if (sel == uart_cfg_pkg::SEL_SHARED || sel == uart_cfg_pkg::SEL_TX) begin
            next_cur.tx_dld = D_IN[5:0];
          end
          if (sel == uart_cfg_pkg::SEL_SHARED || sel == uart_cfg_pkg::SEL_RX) begin
            next_cur.rx_dld = D_IN[5:0];
          end
        end
      end else if (ADDR == uart_cfg_pkg::ADDR_SCRATCH) begin
        if (swap) begin
          next_cur.enhanced_mode_select   = D_IN;
          next_cur.alt_tx = 1'b0;
        end else begin
          next_cur.scratchpad = D_IN;
        end
      end else if (!dlab && !bf && ADDR == uart_cfg_pkg::ADDR_HOLD_DLL) begin
        // A byte into the transmit path turns the line around
        next_cur.dir_tx   = 1'b1;
        next_cur.dir_wait = 1'b0;
      end
    end

    // Read data is captured once at the start of the strobe
    next_cur.doe = cs & ~IOR_N;
    if (rd) begin
      next_cur.dout = uart_cfg_pkg::ZERO8;
      if (ADDR == uart_cfg_pkg::ADDR_LCR) begin
        next_cur.dout = cur.line_control;
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_HOLD_DLL) begin
        next_cur.dout = level;
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_DLM_FEATURE_CONTROL) begin
        next_cur.dout = cur.feature_control;
      end else if (bf && ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
        next_cur.dout = cur.enhanced_feature;
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_HOLD_DLL) begin
        next_cur.dout = (cur.dld_sel == uart_cfg_pkg::SEL_RX) ? cur.rx_dll : cur.tx_dll;
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_DLM_FEATURE_CONTROL) begin
        next_cur.dout = (cur.dld_sel == uart_cfg_pkg::SEL_RX) ? cur.rx_dlm : cur.tx_dlm;
      end else if (dlab && ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
        if (cur.enhanced_feature[uart_cfg_pkg::EFR_ENH_EN]) begin
          next_cur.dout = {cur.dld_sel,
                           (cur.dld_sel == uart_cfg_pkg::SEL_RX) ? cur.rx_dld : cur.tx_dld};
        end
      end else if (ADDR == uart_cfg_pkg::ADDR_ISR_DLD) begin
        next_cur.dout = (cur.xoff_f | cur.xon_f | cur.spec_f) ?
                        uart_cfg_pkg::ISR_FLOW : uart_cfg_pkg::ISR_NONE;
      end else if (ADDR == uart_cfg_pkg::ADDR_SCRATCH) begin
        if (!swap) begin
          next_cur.dout = cur.scratchpad;
        end else if (!cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_CNT_LO]) begin
          next_cur.dout = rxc;
        end else if (!cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_CNT_HI]) begin
          next_cur.dout = sat_count(TX_COUNT);
        end else begin
          next_cur.dout   = cur.alt_tx ? sat_count(TX_COUNT) : rxc;
          next_cur.alt_tx = ~cur.alt_tx;
        end
      end
    end

    // Release the line on the first BIT_TICK at least one cycle after the last stop bit
    if (cur.dir_tx && THR_EMPTY && TSR_EMPTY) begin
      if (!cur.dir_wait) begin
        next_cur.dir_wait = 1'b1;
      end else if (BIT_TICK) begin
        next_cur.dir_tx   = 1'b0;
        next_cur.dir_wait = 1'b0;
      end
    end

    // Auto flow control around the receive trigger
    hyst  = uart_cfg_pkg::HYST_TABLE[{cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_HYST_LO +: 2],
                                      cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_HYST_LO +: 2]}];
    level = (cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_TABLE_LO +: 2] == 2'h3) ? cur.rx_trig : RX_TRIG_LEVEL;
    upper = {1'b0, level} + {1'b0, hyst};
    lower = (hyst > level) ? 9'h000 : ({1'b0, level} - {1'b0, hyst});
    if ({1'b0, rxc} >= upper) begin
      next_cur.flow_n = 1'b1;
    end else if ({1'b0, rxc} < lower) begin
      next_cur.flow_n = 1'b0;
    end

    // Pin select: direction control beats flow control beats general use
    if (auto_dir) begin
      next_cur.rts_n = ~next_cur.dir_tx ^ cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_RTS_INV];
    end else if (cur.enhanced_feature[uart_cfg_pkg::EFR_AUTO_RTS]) begin
      next_cur.rts_n = next_cur.flow_n;
    end else begin
      next_cur.rts_n = GP_RTS_N;
    end

    if (auto_dir) begin
      next_cur.tx_int = THR_EMPTY & TSR_EMPTY;
    end else begin
      next_cur.tx_int = THR_EMPTY;
    end

    if (cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_LSR_IMM]) begin
      next_cur.lsr_int = next_cur.err_seen;
    end else begin
      next_cur.lsr_int = ERR_AT_RHR;
    end

    next_cur.imm_out = next_cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_SEND_IMM] & FIFO_EN;

    // Hysteresis view is registered so the datapath never sees a table glitch
    next_cur.hyst_out = uart_cfg_pkg::HYST_TABLE[{next_cur.enhanced_mode_select[uart_cfg_pkg::ENHANCED_MODE_SELECT_HYST_LO +: 2],
                                                  next_cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_HYST_LO +: 2]}];

    if (!RST_N) begin
      next_cur         = '0;
      next_cur.iow_q   = 1'b1;
      next_cur.ior_q   = 1'b1;
      next_cur.scratchpad     = uart_cfg_pkg::SCRATCH_RESET;
      next_cur.tx_dll  = uart_cfg_pkg::DLL_RESET;
      next_cur.rx_dll  = uart_cfg_pkg::DLL_RESET;
      next_cur.tx_dlm  = uart_cfg_pkg::DLM_RESET;
      next_cur.rx_dlm  = uart_cfg_pkg::DLM_RESET;
      next_cur.rts_n   = 1'b1;
      next_cur.feature_control    = uart_cfg_pkg::ZERO8;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    cur <= next_cur;
  end

  // All outputs below are plain register fields
  assign D_OUT          = cur.dout;
  assign D_OE           = cur.doe;
  assign TX_DIVISOR     = {cur.tx_dlm, cur.tx_dll, cur.tx_dld[3:0]};
  assign RX_DIVISOR     = {cur.rx_dlm, cur.rx_dll, cur.rx_dld[3:0]};
  assign TX_SAMPLE_SEL  = cur.tx_dld[uart_cfg_pkg::DLD_SAMPLE_LO +: 2];
  assign RX_SAMPLE_SEL  = cur.rx_dld[uart_cfg_pkg::DLD_SAMPLE_LO +: 2];
  assign SEND_IMMEDIATE = cur.imm_out;
  assign IR_RX_INVERT   = cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_IR_INV];
  assign TRIG_TABLE     = cur.feature_control[uart_cfg_pkg::FEATURE_CONTROL_TABLE_LO +: 2];
  assign RX_USER_TRIG   = cur.rx_trig;
  assign TX_USER_TRIG   = cur.tx_trig;
  // Table lookup is registered on the same edge as the bit writes
  assign RTS_HYST       = cur.hyst_out;
  assign RTS_N          = cur.rts_n;
  assign TX_INT         = cur.tx_int;
  assign LSR_ERR_INT    = cur.lsr_int;
  assign XOFF_INT       = cur.xoff_f;
  assign XON_INT        = cur.xon_f;
  assign SPECIAL_INT    = cur.spec_f;

endmodule // uart_enh_cfg

// >>> tb/uart_enh_cfg_properties.sv
`timescale 1ns/1ns
module uart_enh_cfg_properties (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Host bus
  input wire logic        CS_N,
  input wire logic        IOR_N,
  input wire logic        IOW_N,
  input wire logic [7:0]  D_OUT,
  input wire logic        D_OE,
  // Status and outputs
  input wire logic        FIFO_EN,
  input wire logic        TX_BYTE_SENT,
  input wire logic        THR_EMPTY,
  input wire logic        XON_RCVD,
  input wire logic        XON_INT,
  input wire logic        SEND_IMMEDIATE,
  input wire logic        TX_INT,
  input wire logic [19:0] TX_DIVISOR,
  input wire logic [19:0] RX_DIVISOR,
  input wire logic [7:0]  RX_USER_TRIG,
  input wire logic [7:0]  TX_USER_TRIG
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd; !CS_N && !IOR_N; endsequence
  sequence s_rd_held; s_rd ##1 s_rd; endsequence
  property p_oe_on; s_rd |=> D_OE; endproperty
  a_oe_on: assert property (p_oe_on) else $error("no drive after read");
  property p_oe_off; IOR_N |=> !D_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive without read");
  property p_dout; s_rd_held |=> $stable(D_OUT); endproperty
  a_dout: assert property (p_dout) else $error("read data moved");
  property p_imm_clr; SEND_IMMEDIATE && TX_BYTE_SENT && IOW_N |=> !SEND_IMMEDIATE; endproperty
  a_imm_clr: assert property (p_imm_clr) else $error("immediate not cleared");
  property p_imm_fifo; !FIFO_EN |=> !SEND_IMMEDIATE; endproperty
  a_imm_fifo: assert property (p_imm_fifo) else $error("immediate without fifo");
  property p_xon_set; XON_RCVD |=> XON_INT; endproperty
  a_xon_set: assert property (p_xon_set) else $error("xon flag not set");
  property p_xon_hold; XON_INT && IOR_N |=> XON_INT; endproperty
  a_xon_hold: assert property (p_xon_hold) else $error("xon flag lost");
  property p_txint; !THR_EMPTY |=> !TX_INT; endproperty
  a_txint: assert property (p_txint) else $error("tx int while full");
  property p_cfg_hold;
    IOW_N |=> $stable({TX_DIVISOR, RX_DIVISOR, TX_USER_TRIG, RX_USER_TRIG});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
endmodule // uart_enh_cfg_properties

bind uart_enh_cfg uart_enh_cfg_properties u_props (.CORE_CLK, .RST_N, .CS_N, .IOR_N,
  .IOW_N, .D_OUT, .D_OE, .FIFO_EN, .TX_BYTE_SENT, .THR_EMPTY, .XON_RCVD, .XON_INT,
  .SEND_IMMEDIATE, .TX_INT, .TX_DIVISOR, .RX_DIVISOR, .RX_USER_TRIG, .TX_USER_TRIG);

// >>> tb/uart_host_model.sv
`timescale 1ns/1ns
module uart_host_model (
  // Clock
  input wire logic       CORE_CLK,
  // Register bus
  output logic           CS_N,
  output logic           IOR_N,
  output logic           IOW_N,
  output logic [2:0]     ADDR,
  output logic [7:0]     D_IN,
  input wire logic [7:0] D_OUT
);
  initial {CS_N, IOR_N, IOW_N, ADDR, D_IN} = 14'h3fff;
  // Strobe held over two edges so read data is settled; released lines show garbage
  task acc(input logic rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge CORE_CLK);
    {CS_N, IOR_N, IOW_N, ADDR, D_IN} = {1'b0, !rd, rd, a, d};
    repeat (2) @(negedge CORE_CLK);
    q = D_OUT;
    {CS_N, IOR_N, IOW_N, ADDR, D_IN} = {3'h7, ~ADDR, ~D_IN};
  endtask
endmodule // uart_host_model

// >>> tb/test_uart_enh_cfg.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module test_uart_enh_cfg;
  logic        CORE_CLK, RST_N, CS_N, IOR_N, IOW_N, D_OE, FIFO_EN, TX_BYTE_SENT;
  logic        THR_EMPTY, TSR_EMPTY, BIT_TICK, ERR_AT_RHR, ERR_INTO_FIFO, GP_RTS_N;
  logic        XOFF_RCVD, XON_RCVD, SPECIAL_RCVD, CHAR_RCVD, SEND_IMMEDIATE, IR_RX_INVERT;
  logic        RTS_N, TX_INT, LSR_ERR_INT, XOFF_INT, XON_INT, SPECIAL_INT;
  logic [2:0]  ADDR;
  logic [7:0]  D_IN, D_OUT, RX_TRIG_LEVEL, RX_USER_TRIG, TX_USER_TRIG, RTS_HYST, q;
  logic [6:0]  RX_COUNT, TX_COUNT;
  logic [19:0] TX_DIVISOR, RX_DIVISOR;
  logic [1:0]  TX_SAMPLE_SEL, RX_SAMPLE_SEL, TRIG_TABLE;
  logic [31:0] seed = 32'h8824;
  logic [31:0] noise = 32'h8824;
  int miscompares, n_compared, cycles, txd, rxd, txs, rxs, sel, e;
  int hyst [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

  uart_enh_cfg u_dut (.*);
  uart_host_model u_host (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int sat(input int c);
    return (c > 64) ? 64 : c;
  endfunction
  task wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.acc(1'b0, a, d, x);
  endtask
  task rd(input logic [2:0] a);
    u_host.acc(1'b1, a, 8'h00, q);
  endtask
  task automatic pulse(ref logic s);
    @(negedge CORE_CLK);
    s = 1'b1;
    @(negedge CORE_CLK);
    s = 1'b0;
    @(negedge CORE_CLK);
  endtask
  task results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  // Side inputs wander so unrelated logic is exercised under the checks
  always @(negedge CORE_CLK) begin
    noise = lfsr(noise);
    {BIT_TICK, ERR_AT_RHR, GP_RTS_N, RX_TRIG_LEVEL} = noise[10:0];
  end
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    {RST_N, FIFO_EN, TX_BYTE_SENT, THR_EMPTY, TSR_EMPTY, ERR_INTO_FIFO} = 6'h00;
    {XOFF_RCVD, XON_RCVD, SPECIAL_RCVD, CHAR_RCVD, BIT_TICK, ERR_AT_RHR, GP_RTS_N} = 7'h00;
    {RX_COUNT, TX_COUNT, RX_TRIG_LEVEL} = 22'h0;
    {txd, rxd, txs, rxs} = {32'd16, 32'd16, 32'd0, 32'd0};
    repeat (20) @(negedge CORE_CLK);
    RST_N = 1'b1;
    `CHK(RTS_HYST, 8'h00)
    `CHK(TX_DIVISOR, 20'h00010)
    rd(3'h7);
    `CHK(q, 8'hff)
    seed = lfsr(seed);
    wr(3'h7, seed[7:0]);
    rd(3'h7);
    `CHK(q, seed[7:0])
    $display("test reset and scratchpad done");
    wr(3'h3, uart_cfg_pkg::LCR_ENH_ACCESS);
    wr(3'h2, 8'h10);
    for (int i = 0; i < 16; i++) begin
      wr(3'h1, 8'h40 | (i[1:0] << 4) | (i[0] << 2) | i[1:0]);
      wr(3'h7, i[3:2] << 4);
      `CHK(RTS_HYST, hyst[i][7:0])
      `CHK(TRIG_TABLE, i[1:0])
      `CHK(IR_RX_INVERT, i[0])
    end
    $display("test hysteresis and tables done");
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      RX_COUNT = (m == 0) ? 7'h7f : seed[6:0];
      TX_COUNT = seed[14:8];
      wr(3'h7, m[7:0]);
      for (int k = 0; k < 3; k++) begin
        rd(3'h7);
        e = (m == 1 || (m == 3 && k % 2 == 1)) ? sat(TX_COUNT) : sat(RX_COUNT);
        `CHK(q, e[7:0])
      end
      wr(3'h1, {m[0], 7'h40});
      wr(3'h0, seed[23:16]);
      `CHK(m[0] ? TX_USER_TRIG : RX_USER_TRIG, seed[23:16])
      rd(3'h0);
      `CHK(q, sat(m[0] ? TX_COUNT : RX_COUNT))
    end
    $display("test level count done");
    FIFO_EN = 1'b1;
    wr(3'h7, 8'h04);
    `CHK(SEND_IMMEDIATE, 1'b1)
    pulse(TX_BYTE_SENT);
    `CHK(SEND_IMMEDIATE, 1'b0)
    wr(3'h3, 8'h80);
    for (int j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      sel = (j == 2) ? 3 : (j == 3) ? 2 : j;
      wr(3'h2, {sel[1:0], seed[5:0]});
      wr(3'h0, seed[15:8]);
      wr(3'h1, seed[23:16]);
      e = {seed[23:8], seed[3:0]};
      if (sel == 0 || sel == 1) {txd, txs} = {e, 32'(seed[5:4])};
      if (sel == 0 || sel == 3) {rxd, rxs} = {e, 32'(seed[5:4])};
      `CHK(TX_DIVISOR, txd[19:0])
      `CHK(RX_DIVISOR, rxd[19:0])
      `CHK({TX_SAMPLE_SEL, RX_SAMPLE_SEL}, {txs[1:0], rxs[1:0]})
    end
    $display("test divisors done");
    wr(3'h3, 8'h00);
    wr(3'h7, 8'h00);
    pulse(XOFF_RCVD);
    `CHK(XOFF_INT, 1'b1)
    pulse(XON_RCVD);
    `CHK({XOFF_INT, XON_INT}, 2'b01)
    pulse(SPECIAL_RCVD);
    pulse(CHAR_RCVD);
    `CHK(SPECIAL_INT, 1'b0)
    rd(3'h2);
    `CHK({q, XON_INT}, {uart_cfg_pkg::ISR_FLOW, 1'b0})
    wr(3'h7, 8'h80);
    pulse(XOFF_RCVD);
    pulse(XON_RCVD);
    `CHK(XOFF_INT, 1'b1)
    rd(3'h2);
    rd(3'h2);
    `CHK({q, XOFF_INT}, {uart_cfg_pkg::ISR_NONE, 1'b0})
    $display("test interrupts done");
    THR_EMPTY = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    `CHK(TX_INT, 1'b1)
    wr(3'h3, uart_cfg_pkg::LCR_ENH_ACCESS);
    wr(3'h1, 8'h48);
    wr(3'h3, 8'h00);
    `CHK(TX_INT, 1'b0)
    THR_EMPTY = 1'b0;
    wr(3'h0, 8'h5a);
    @(negedge CORE_CLK);
    `CHK(RTS_N, 1'b0)
    {THR_EMPTY, TSR_EMPTY} = 2'b11;
    for (int n = 0; n < 40 && RTS_N !== 1'b1; n++) @(negedge CORE_CLK);
    `CHK({RTS_N, TX_INT}, 2'b11)
    {THR_EMPTY, TSR_EMPTY} = 2'b00;
    wr(3'h7, 8'h08);
    wr(3'h0, 8'ha5);
    @(negedge CORE_CLK);
    `CHK(RTS_N, 1'b1)
    $display("test direction done");
    wr(3'h7, 8'h00);
    repeat (4) begin
      @(posedge CORE_CLK);
      #1;
      `CHK(LSR_ERR_INT, ERR_AT_RHR)
    end
    wr(3'h7, 8'h40);
    pulse(ERR_INTO_FIFO);
    `CHK(LSR_ERR_INT, 1'b1)
    rd(3'h5);
    @(negedge CORE_CLK);
    `CHK(LSR_ERR_INT, 1'b0)
    $display("test error interrupt done");
    wr(3'h3, uart_cfg_pkg::LCR_ENH_ACCESS);
    wr(3'h1, 8'h71);
    wr(3'h2, 8'h50);
    wr(3'h0, 8'h10);
    for (int r = 0; r < 3; r++) begin
      RX_COUNT = (r == 0) ? 7'd20 : (r == 1) ? 7'd15 : 7'd11;
      repeat (2) @(negedge CORE_CLK);
      `CHK(RTS_N, r != 2)
    end
    wr(3'h2, 8'h10);
    @(posedge CORE_CLK);
    #1;
    `CHK(RTS_N, GP_RTS_N)
    $display("test flow control done");
    results();
  end
endmodule // test_uart_enh_cfg
